// *** src/ccrf_core.sv ***
// decode and execute of relative call, soft reset and the return group
//
// What this block does
// - relative call pushes next address, then jumps to it plus twice offset
// - relative call takes two cycles; work in first, second is a no-op
// - soft reset opcode returns all master-clear state to reset values, one cycle
// - interrupt return pops stack into pc and sets one interrupt enable; two cycles
// - interrupt return changes no flags beyond the interrupt enable bits
// - interrupt return with fast bit restores acc, flags, bank from shadows
// - literal return loads literal into acc and pc from popped top; two cycles
// - return group leaves pc high and upper latches untouched
// - plain return pops stack into pc, no flags touched, two cycles
// - plain return with fast bit restores acc, flags, bank from shadows
// - relative call carries an 11-bit signed word offset in its low bits
`timescale 1ns/1ps
`default_nettype none

module ccrf_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [ccrf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ccrf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ccrf_pkg::DATA_W-1:0] reg_rdata,
  output logic [ccrf_pkg::PC_W-1:0] pc_out,
  output logic [1:0] q_phase,
  output logic fetch_flush,
  output logic soft_reset_busy
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  // async assert, two-flop release so every flop leaves reset together
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------
  ccrf_pkg::ccrf_bus_type bus;
  ccrf_pkg::ccrf_dec_type dec_next;
  ccrf_pkg::ccrf_dec_type dec_reg;
  ccrf_pkg::ccrf_state_type state_reg;
  logic [1:0] q_reg;
  logic soft_rst_reg;
  logic [ccrf_pkg::PC_W-1:0] pc_reg;
  logic [ccrf_pkg::PC_W-1:0] pc_inc;
  logic [ccrf_pkg::PC_W-1:0] call_target;
  logic [ccrf_pkg::SP_W-1:0] sp_reg;
  logic [ccrf_pkg::PC_W-1:0] stack_top;
  logic [7:0] acc_reg;
  logic [ccrf_pkg::FLAGS_W-1:0] flags_reg;
  logic [ccrf_pkg::BANK_W-1:0] bank_select_reg;
  logic [7:0] acc_shadow_reg;
  logic [ccrf_pkg::FLAGS_W-1:0] flags_shadow_reg;
  logic [ccrf_pkg::BANK_W-1:0] bank_shadow_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] pc_upper_latch_reg;
  logic prio_mode_reg;
  logic high_prio_irq_enable_reg;  // also the global enable when prio mode is off
  logic low_prio_irq_enable_reg;   // also the peripheral enable when prio mode is off
  logic exec;
  logic do_push;
  logic do_pop;
  logic do_fast;
  logic clr;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign clr = soft_rst_reg;

  // ------------------------------------------------------------
  // quarter phase counter and instruction sequencing
  // ------------------------------------------------------------

  // q phase keeps running through a soft reset so fetch timing stays aligned
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      q_reg <= ccrf_pkg::Q1;
    end else begin
      q_reg <= q_reg + 2'h1;
    end
  end

  // opcode decode, looked at only in q1 of a non-flushed cycle
  always_comb begin
    dec_next = '{kind: ccrf_pkg::OPK_NONE, fast: instr_word[0], literal: instr_word[7:0],
                 offset: instr_word[ccrf_pkg::OFS_W-1:0]};
    if (instr_word[15:11] == ccrf_pkg::OP_RELATIVE_CALL_HI) begin
      dec_next.kind = ccrf_pkg::OPK_RELATIVE_CALL;
    end else if (instr_word == ccrf_pkg::OP_SOFT_RESET) begin
      dec_next.kind = ccrf_pkg::OPK_SRESET;
    end else if (instr_word[15:1] == ccrf_pkg::OP_IRET_HI) begin
      dec_next.kind = ccrf_pkg::OPK_IRET;
    end else if (instr_word[15:1] == ccrf_pkg::OP_RET_HI) begin
      dec_next.kind = ccrf_pkg::OPK_RET;
    end else if (instr_word[15:8] == ccrf_pkg::OP_LRET_HI) begin
      dec_next.kind = ccrf_pkg::OPK_LRET;
    end
  end

  // latch the decoded word at q1; other opcodes belong to other units
  // a soft reset keeps its own decode until q4, so the pc step there is skipped and pc stays at zero
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      dec_reg <= '0;
    end else if (q_reg == ccrf_pkg::Q1) begin
      if (state_reg == ccrf_pkg::ST_RUN && instr_valid) begin
        dec_reg <= dec_next;
      end else begin
        dec_reg <= '0;
      end
    end
  end

  // the q4 edge commits instruction writes; soft reset clears and register-port writes land on other edges too
  assign exec = (q_reg == ccrf_pkg::Q4);
  assign do_push = exec && dec_reg.kind == ccrf_pkg::OPK_RELATIVE_CALL;
  assign do_pop = exec && (dec_reg.kind == ccrf_pkg::OPK_IRET || dec_reg.kind == ccrf_pkg::OPK_RET ||
                           dec_reg.kind == ccrf_pkg::OPK_LRET);
  assign do_fast = do_pop && dec_reg.fast && dec_reg.kind != ccrf_pkg::OPK_LRET;

  // two-cycle opcodes flush the next fetch with a no-op cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= ccrf_pkg::ST_RUN;
    end else if (clr) begin
      state_reg <= ccrf_pkg::ST_RUN;
    end else if (exec) begin
      case (state_reg)
        ccrf_pkg::ST_RUN: begin
          if (do_push || do_pop) begin
            state_reg <= ccrf_pkg::ST_NOP;
          end
        end
        ccrf_pkg::ST_NOP: begin
          state_reg <= ccrf_pkg::ST_RUN;
        end
        default: begin
          state_reg <= ccrf_pkg::ST_RUN;
        end
      endcase
    end
  end

  // soft reset is seen in q2, raises busy on the next edge and clears state on the edge after that
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= (q_reg == ccrf_pkg::Q2) && dec_reg.kind == ccrf_pkg::OPK_SRESET;
    end
  end

  // ------------------------------------------------------------
  // program counter and return stack
  // ------------------------------------------------------------
  assign pc_inc = pc_reg + ccrf_pkg::PC_STEP;
  // sign-extend the word offset and double it to a byte offset
  assign call_target = pc_inc + {{(ccrf_pkg::PC_W - ccrf_pkg::OFS_W - 1){dec_reg.offset[ccrf_pkg::OFS_W-1]}},
                                 dec_reg.offset, 1'b0};

  // pc steps one word per cycle; no step during the flushed cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pc_reg <= ccrf_pkg::RST_PC;
    end else if (clr) begin
      pc_reg <= ccrf_pkg::RST_PC;
    end else if (do_push) begin
      pc_reg <= call_target;
    end else if (do_pop) begin
      pc_reg <= stack_top;
    end else if (exec && state_reg == ccrf_pkg::ST_RUN && dec_reg.kind != ccrf_pkg::OPK_SRESET) begin
      pc_reg <= pc_inc;
    end
  end

  // pointer moves up before the write lands, down after a pop; wraps silently
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sp_reg <= ccrf_pkg::RST_SP;
    end else if (clr) begin
      sp_reg <= ccrf_pkg::RST_SP;
    end else if (do_push) begin
      sp_reg <= sp_reg + 5'h01;
    end else if (do_pop) begin
      sp_reg <= sp_reg - 5'h01;
    end
  end

  // read port always tracks the pointer, so the top is ready long before q4
  ccrf_stack_mem u_stack (
    .sys_clk(sys_clk),
    .wr_en(do_push),
    .wr_addr(sp_reg + 5'h01),
    .wr_data(pc_inc),
    .rd_addr(sp_reg),
    .rd_data(stack_top)
  );

  // ------------------------------------------------------------
  // working and shadow registers
  // ------------------------------------------------------------

  // instruction writes win over a same-cycle software write
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      acc_reg <= ccrf_pkg::RST_BYTE;
      flags_reg <= '0;
      bank_select_reg <= '0;
    end else if (clr) begin
      acc_reg <= ccrf_pkg::RST_BYTE;
      flags_reg <= '0;
      bank_select_reg <= '0;
    end else if (do_fast) begin
      acc_reg <= acc_shadow_reg;
      flags_reg <= flags_shadow_reg;
      bank_select_reg <= bank_shadow_reg;
    end else if (do_pop && dec_reg.kind == ccrf_pkg::OPK_LRET) begin
      acc_reg <= dec_reg.literal;
    end else if (bus.wr) begin
      // flags untouched by any of these opcodes apart from the fast restore and the soft reset clear
      if (bus.addr == ccrf_pkg::REG_ACC) acc_reg <= bus.wdata;
      if (bus.addr == ccrf_pkg::REG_FLAGS) flags_reg <= bus.wdata[ccrf_pkg::FLAGS_W-1:0];
      if (bus.addr == ccrf_pkg::REG_BANK) bank_select_reg <= bus.wdata[ccrf_pkg::BANK_W-1:0];
    end
  end

  // shadows and pc latches are software-owned here; the return group never writes them
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      acc_shadow_reg <= ccrf_pkg::RST_BYTE;
      flags_shadow_reg <= '0;
      bank_shadow_reg <= '0;
      pc_high_latch_reg <= ccrf_pkg::RST_BYTE;
      pc_upper_latch_reg <= ccrf_pkg::RST_BYTE;
    end else if (clr) begin
      acc_shadow_reg <= ccrf_pkg::RST_BYTE;
      flags_shadow_reg <= '0;
      bank_shadow_reg <= '0;
      pc_high_latch_reg <= ccrf_pkg::RST_BYTE;
      pc_upper_latch_reg <= ccrf_pkg::RST_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == ccrf_pkg::REG_ACC_SH) acc_shadow_reg <= bus.wdata;
      if (bus.addr == ccrf_pkg::REG_FLAGS_SH) flags_shadow_reg <= bus.wdata[ccrf_pkg::FLAGS_W-1:0];
      if (bus.addr == ccrf_pkg::REG_BANK_SH) bank_shadow_reg <= bus.wdata[ccrf_pkg::BANK_W-1:0];
      if (bus.addr == ccrf_pkg::REG_PC_HIGH_LATCH) pc_high_latch_reg <= bus.wdata;
      if (bus.addr == ccrf_pkg::REG_PC_UPPER_LATCH) pc_upper_latch_reg <= bus.wdata;
    end
  end

  // ------------------------------------------------------------
  // interrupt enables
  // ------------------------------------------------------------

  // in priority mode the high enable is reopened first, else the low one
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      prio_mode_reg <= 1'b0;
      high_prio_irq_enable_reg <= 1'b0;
      low_prio_irq_enable_reg <= 1'b0;
    end else if (clr) begin
      prio_mode_reg <= 1'b0;
      high_prio_irq_enable_reg <= 1'b0;
      low_prio_irq_enable_reg <= 1'b0;
    end else if (do_pop && dec_reg.kind == ccrf_pkg::OPK_IRET) begin
      if (!prio_mode_reg || !high_prio_irq_enable_reg) begin
        high_prio_irq_enable_reg <= 1'b1;
      end else begin
        low_prio_irq_enable_reg <= 1'b1;
      end
    end else if (bus.wr && bus.addr == ccrf_pkg::REG_CTRL) begin
      prio_mode_reg <= bus.wdata[ccrf_pkg::CTRL_PRIO_BIT];
      high_prio_irq_enable_reg <= bus.wdata[ccrf_pkg::CTRL_GE_BIT];
      low_prio_irq_enable_reg <= bus.wdata[ccrf_pkg::CTRL_PE_BIT];
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------

  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      reg_rdata <= ccrf_pkg::RST_BYTE;
    end else if (bus.rd) begin
      case (bus.addr)
        ccrf_pkg::REG_CTRL: reg_rdata <= {5'h00, low_prio_irq_enable_reg, high_prio_irq_enable_reg, prio_mode_reg};
        ccrf_pkg::REG_ACC: reg_rdata <= acc_reg;
        ccrf_pkg::REG_FLAGS: reg_rdata <= {3'h0, flags_reg};
        ccrf_pkg::REG_BANK: reg_rdata <= {4'h0, bank_select_reg};
        ccrf_pkg::REG_ACC_SH: reg_rdata <= acc_shadow_reg;
        ccrf_pkg::REG_FLAGS_SH: reg_rdata <= {3'h0, flags_shadow_reg};
        ccrf_pkg::REG_BANK_SH: reg_rdata <= {4'h0, bank_shadow_reg};
        ccrf_pkg::REG_PC_LOW: reg_rdata <= pc_reg[7:0];
        ccrf_pkg::REG_STATUS: reg_rdata <= {state_reg == ccrf_pkg::ST_NOP, 2'h0, sp_reg};
        ccrf_pkg::REG_PC_HIGH_LATCH: reg_rdata <= pc_high_latch_reg;
        ccrf_pkg::REG_PC_UPPER_LATCH: reg_rdata <= pc_upper_latch_reg;
        default: reg_rdata <= ccrf_pkg::RST_BYTE;
      endcase
    end else begin
      reg_rdata <= ccrf_pkg::RST_BYTE;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pc_out = pc_reg;
  assign q_phase = q_reg;
  assign fetch_flush = (state_reg == ccrf_pkg::ST_NOP);
  assign soft_reset_busy = soft_rst_reg;

endmodule

`default_nettype wire

// *** src/ccrf_pkg.sv ***
// shared constants and types for the call/return flow decoder
package ccrf_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // quarter phases of one instruction cycle
  // ----------------------------------------------------------------
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q4 = 2'h3;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_RELATIVE_CALL_HI = 5'h1b;     // top five bits 1101 1
  localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;
  localparam logic [14:0] OP_IRET_HI = 15'h0008;  // 0000 0000 0001 000s
  localparam logic [14:0] OP_RET_HI = 15'h0009;   // 0000 0000 0001 001s
  localparam logic [7:0] OP_LRET_HI = 8'h0c;      // 0000 1100 kkkk kkkk
  localparam int OFS_W = 11;

  // ----------------------------------------------------------------
  // register map, word indexes on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;   // bit0 prio mode, bit1 ge/high, bit2 pe/low
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_FLAGS = 4'h2;
  localparam logic [3:0] REG_BANK = 4'h3;
  localparam logic [3:0] REG_ACC_SH = 4'h4;
  localparam logic [3:0] REG_FLAGS_SH = 4'h5;
  localparam logic [3:0] REG_BANK_SH = 4'h6;
  localparam logic [3:0] REG_PC_LOW = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8; // bits4:0 stack pointer, bit7 second cycle
  localparam logic [3:0] REG_PC_HIGH_LATCH = 4'h9;
  localparam logic [3:0] REG_PC_UPPER_LATCH = 4'ha;

  localparam int CTRL_PRIO_BIT = 0;
  localparam int CTRL_GE_BIT = 1;
  localparam int CTRL_PE_BIT = 2;
  localparam int STATUS_BUSY_BIT = 7;
  localparam int FLAGS_W = 5;
  localparam int BANK_W = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [SP_W-1:0] RST_SP = 5'h00;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_NOP = 1'b1
  } ccrf_state_type;

  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_RELATIVE_CALL = 3'h1,
    OPK_SRESET = 3'h2,
    OPK_IRET = 3'h3,
    OPK_LRET = 3'h4,
    OPK_RET = 3'h5
  } ccrf_opk_type;

  typedef struct packed {
    ccrf_opk_type kind;
    logic fast;
    logic [7:0] literal;
    logic [OFS_W-1:0] offset;
  } ccrf_dec_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccrf_bus_type;

endpackage

// *** src/ccrf_stack_mem.sv ***
// return-address stack storage with registered read
`timescale 1ns/1ps
`default_nettype none

module ccrf_stack_mem (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [ccrf_pkg::SP_W-1:0] wr_addr,
  input wire logic [ccrf_pkg::PC_W-1:0] wr_data,
  input wire logic [ccrf_pkg::SP_W-1:0] rd_addr,
  output logic [ccrf_pkg::PC_W-1:0] rd_data
);

  logic [ccrf_pkg::PC_W-1:0] mem [0:(1 << ccrf_pkg::SP_W)-1];

  // no reset on the array: contents are only meaningful once pushed
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// *** tb/ccrf_core_props.sv ***
// port-level assertion checker for the call/return flow decoder
`timescale 1ns/1ps
`default_nettype none

module ccrf_core_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [ccrf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ccrf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ccrf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [ccrf_pkg::PC_W-1:0] pc_out,
  input wire logic [1:0] q_phase,
  input wire logic fetch_flush,
  input wire logic soft_reset_busy
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic q3_seen_reg;
  logic take, is_call, is_sr, is_two, is_other;
  // a take needs a Q4 just before, so idle phase-0 edges after reset release never count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q3_seen_reg <= 1'b0;
    end else begin
      q3_seen_reg <= (q_phase == ccrf_pkg::Q4);
    end
  end
  // opcode classes of the word being sampled
  assign take = (q_phase == ccrf_pkg::Q1) && q3_seen_reg && instr_valid && !fetch_flush;
  assign is_call = instr_word[15:11] == ccrf_pkg::OP_RELATIVE_CALL_HI;
  assign is_sr = instr_word == ccrf_pkg::OP_SOFT_RESET;
  assign is_two = is_call || instr_word[15:1] == ccrf_pkg::OP_IRET_HI || instr_word[15:1] == ccrf_pkg::OP_RET_HI
    || instr_word[15:8] == ccrf_pkg::OP_LRET_HI;
  assign is_other = !is_two && !is_sr;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_flush;
    fetch_flush [*4] ##1 !fetch_flush;
  endsequence
  sequence s_cleared;
    !soft_reset_busy && pc_out == 21'h000000 && !fetch_flush;
  endsequence
  property p_call;
    logic [20:0] p;
    logic [10:0] n;
    (take && is_call, p = pc_out, n = instr_word[10:0]) |-> ##4 pc_out == p + 21'h000002 + {{9{n[10]}}, n, 1'b0};
  endproperty
  property p_step;
    logic [20:0] p;
    (take && is_other, p = pc_out) |-> ##4 (pc_out == p + 21'h000002) && !fetch_flush;
  endproperty
  property p_pc_read;
    logic [7:0] b;
    (reg_rd && reg_addr == ccrf_pkg::REG_PC_LOW, b = pc_out[7:0]) |=> reg_rdata == b;
  endproperty

  a_call_target: assert property (p_call) else $error("call target wrong");
  a_two_cycle: assert property (take && is_two |-> ##4 s_flush) else $error("no single flush cycle");
  a_plain_step: assert property (p_step) else $error("ordinary step wrong");
  a_sreset_seq: assert property (take && is_sr |-> ##2 soft_reset_busy ##1 s_cleared) else $error("soft reset");
  a_busy_phase: assert property (soft_reset_busy |-> q_phase == 2'h2) else $error("busy phase");
  a_pc_hold: assert property (q_phase != ccrf_pkg::Q4 && !soft_reset_busy |=> $stable(pc_out)) else $error("pc moved");
  a_phase_wrap: assert property (q_phase == 2'h3 |=> q_phase == 2'h0 ##3 q_phase == 2'h3) else $error("phase count");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_pc_read: assert property (p_pc_read) else $error("pc low read wrong");
endmodule

bind ccrf_core ccrf_core_props i_ccrf_core_props (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .instr_word(instr_word),
  .instr_valid(instr_valid),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .pc_out(pc_out),
  .q_phase(q_phase),
  .fetch_flush(fetch_flush),
  .soft_reset_busy(soft_reset_busy)
);
`default_nettype wire

// *** tb/ccrf_core_tb.sv ***
// self-checking bench for the call/return flow decoder
`timescale 1ns/1ps
`default_nettype none

module ccrf_core_tb;
  logic sys_clk, rstn, instr_valid, reg_wr, reg_rd, fetch_flush, soft_reset_busy;
  logic [15:0] instr_word;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [20:0] pc_out;
  logic [1:0] q_phase;
  int errors = 0;
  int n_checks = 0;

  ccrf_core i_ccrf_core (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .instr_word(instr_word),
    .instr_valid(instr_valid),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pc_out(pc_out),
    .q_phase(q_phase),
    .fetch_flush(fetch_flush),
    .soft_reset_busy(soft_reset_busy)
  );

  // ----------------------------------------------------------------
  // clock and shared tasks
  // ----------------------------------------------------------------
  // 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // present one word for a whole cycle, return just after its commit edge; a nop fills behind it
  task automatic exec(input logic [15:0] word);
    @(negedge sys_clk);
    while (q_phase !== 2'h3) @(negedge sys_clk);
    @(posedge sys_clk);
    instr_word <= word;
    instr_valid <= 1'b1;
    repeat (4) @(posedge sys_clk);
    instr_word <= 16'h0000;
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so it is judged mid-cycle there
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(21'(reg_rdata), 21'(exp));
  endtask

  // pc low byte is skipped: the filler nop keeps moving it
  task automatic rd_zero_all;
    for (int i = 0; i < 11; i++) begin
      if (i != 7) begin
        rd_chk(4'(i), 8'h00);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rd_zero_all();
    wr(4'hf, 8'hff);
    rd_chk(4'hf, 8'h00);
  endtask

  task automatic t_call_ret;
    exec(ccrf_pkg::OP_SOFT_RESET);
    chk(pc_out, 21'h000000);
    exec(16'hd805);
    chk(pc_out, 21'h00000e);
    rd_chk(ccrf_pkg::REG_STATUS, 8'h81);
    exec(16'hdc00);
    chk(pc_out, 21'h1ff810);
    rd_chk(ccrf_pkg::REG_PC_LOW, 8'h10);
    wr(ccrf_pkg::REG_ACC_SH, 8'ha5);
    wr(ccrf_pkg::REG_FLAGS_SH, 8'h15);
    wr(ccrf_pkg::REG_BANK_SH, 8'h09);
    wr(ccrf_pkg::REG_FLAGS, 8'h0a);
    wr(ccrf_pkg::REG_PC_HIGH_LATCH, 8'h3c);
    wr(ccrf_pkg::REG_PC_UPPER_LATCH, 8'h1b);
    exec(16'h0012);
    chk(pc_out, 21'h000010);
    rd_chk(ccrf_pkg::REG_ACC, 8'h00);
    rd_chk(ccrf_pkg::REG_FLAGS, 8'h0a);
    exec(16'h0013);
    chk(pc_out, 21'h000004);
    rd_chk(ccrf_pkg::REG_STATUS, 8'h80);
    rd_chk(ccrf_pkg::REG_ACC, 8'ha5);
    rd_chk(ccrf_pkg::REG_FLAGS, 8'h15);
    rd_chk(ccrf_pkg::REG_BANK, 8'h09);
    rd_chk(ccrf_pkg::REG_PC_HIGH_LATCH, 8'h3c);
    rd_chk(ccrf_pkg::REG_PC_UPPER_LATCH, 8'h1b);
  endtask

  task automatic t_iret;
    exec(ccrf_pkg::OP_SOFT_RESET);
    exec(16'hd801);
    wr(ccrf_pkg::REG_FLAGS, 8'h0a);
    wr(ccrf_pkg::REG_ACC_SH, 8'h3c);
    exec(16'h0010);
    chk(pc_out, 21'h000004);
    rd_chk(ccrf_pkg::REG_CTRL, 8'h02);
    rd_chk(ccrf_pkg::REG_FLAGS, 8'h0a);
    rd_chk(ccrf_pkg::REG_ACC, 8'h00);
    wr(ccrf_pkg::REG_CTRL, 8'h03);
    wr(ccrf_pkg::REG_FLAGS_SH, 8'h11);
    wr(ccrf_pkg::REG_BANK_SH, 8'h06);
    exec(16'hd801);
    exec(16'h0011);
    rd_chk(ccrf_pkg::REG_CTRL, 8'h07);
    rd_chk(ccrf_pkg::REG_ACC, 8'h3c);
    rd_chk(ccrf_pkg::REG_FLAGS, 8'h11);
    rd_chk(ccrf_pkg::REG_BANK, 8'h06);
  endtask

  task automatic t_lret;
    exec(ccrf_pkg::OP_SOFT_RESET);
    exec(16'hd8ff);
    chk(pc_out, 21'h000202);
    exec(16'h0c5a);
    chk(pc_out, 21'h000004);
    rd_chk(ccrf_pkg::REG_ACC, 8'h5a);
    wr(ccrf_pkg::REG_BANK, 8'h05);
    wr(ccrf_pkg::REG_CTRL, 8'h07);
    exec(ccrf_pkg::OP_SOFT_RESET);
    chk(pc_out, 21'h000000);
    rd_zero_all();
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence; strobes and instruction stay idle until the reset copy is out
  initial begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset_values();
    t_call_ret();
    t_iret();
    t_lret();
    print_verdict();
  end

  // the tests need well under a thousand cycles; 50000 means a hang
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
